// [hw/csei_regs.svh]
// Register offsets, field positions and reset values of the sideband unit
`ifndef CSEI_REGS_SVH
`define CSEI_REGS_SVH
// Register byte offsets
`define CSEI_CTRL_OFF     12'h000
`define CSEI_STATUS_OFF   12'h004
`define CSEI_MASK_OFF     12'h008
`define CSEI_STATE_OFF    12'h00C
`define CSEI_VECTOR_OFF   12'h010
// Control register fields
`define CSEI_CTRL_NATIVE_BIT 0
`define CSEI_CTRL_LIC_BIT    1
`define CSEI_CTRL_ERR_BIT    2
`define CSEI_CTRL_FPERR_BIT  3
`define CSEI_CTRL_FPOP_BIT   4
`define CSEI_CTRL_STALL_BIT  5
`define CSEI_CTRL_RESET      32'h0000_0002
// Event bits of status and mask
`define CSEI_EV_INTERR  0
`define CSEI_EV_FPEXC   1
`define CSEI_EV_INIT    2
`define CSEI_EV_IRQ     3
`define CSEI_EV_NMI     4
`define CSEI_EV_BITS    5
`define CSEI_MASK_RESET 5'h00
// Default reset vector
`define CSEI_VECTOR_RESET 32'hFFFF_FFF0
// AXI responses
`define CSEI_RESP_OKAY   2'h0
`define CSEI_RESP_SLVERR 2'h2
`endif

// [hw/csei_pkg.sv]
// Types shared by the sideband error and init unit
package csei_pkg;
	// Asynchronous sideband inputs, sampled as one group
	typedef struct packed {
		logic initReq;
		logic ignoreNumericErrorIn;
		logic localIrqPinOne;
		logic localIrqPinZero;
	} csei_async_t;
	// Snoop result driven onto the bus
	typedef struct packed {
		logic snoopHit;
		logic snoopHitModified;
	} csei_snoop_t;
	// Bus cycle kinds issued by the unit
	typedef enum logic [1:0] {
		CSEI_CYC_NONE = 2'h0,
		CSEI_CYC_BUS_CYCLE_A = 2'h1
	} csei_cycle_t;
	// Soft init sequencer states
	typedef enum logic [2:0] {
		CSEI_RUN   = 3'b001,
		CSEI_INIT  = 3'b010,
		CSEI_FETCH = 3'b100
	} csei_state_t;
endpackage

// [hw/cpu_sideband_error_init_logic.sv]
// Sideband error, numeric error, soft init and local interrupt unit
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "csei_regs.svh"
module cpu_sideband_error_init_logic
	import csei_pkg::*;
(
	input  wire logic        core_clk,            // Bus clock
	input  wire logic        resetn,              // Async reset, active low
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Sideband pins, asynchronous
	input  wire csei_async_t asyncIn,
	// Core side
	input  wire logic        internalErrorEvent,  // One-cycle error pulse
	input  wire logic        snoopReq,            // Snoop request pulse
	input  wire logic        snoopNeedsStall,     // Snoop lookup not ready
	input  wire logic        snoopHitLine,        // Line present
	input  wire logic        snoopDirtyLine,      // Line modified
	// Pin side outputs
	output csei_snoop_t      snoopOut,            // Snoop result
	output logic             internal_error_out,  // Held error, active high
	output csei_cycle_t      busCycle,            // Bus cycle request
	output logic             maskable_irq,        // Maskable irq request
	output logic             nmiOut,              // Nonmaskable irq
	output logic [1:0]       local_irq_pins,      // Pins to controller
	output logic             intRegReset,         // Integer regs reset
	output logic             cacheInvalidate,     // Cache invalidate pulse
	output logic             fetchStart,          // Fetch restart pulse
	output logic [31:0]      fetchVector,         // Fetch address
	output logic             irq                  // Unit interrupt
);
	// ======================================================
	// Reset release
	// ======================================================
	logic rstMeta_r, rstSync_r, rstn;
	// Async assert, synchronous release
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end
		else
		begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end
	assign rstn = rstSync_r;

	// ======================================================
	// Input synchronisers
	// ======================================================
	csei_async_t asyncMeta_r, asyncSync_r;
	// Two stages per pin; only the second is used
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			asyncMeta_r <= '0;
			asyncSync_r <= '0;
		end
		else
		begin
			asyncMeta_r <= asyncIn;
			asyncSync_r <= asyncMeta_r;
		end
	end

	// ======================================================
	// Registers and state
	// ======================================================
	logic [31:0]             ctrl_r, ctrl_nxt;        // Control bits
	logic [`CSEI_EV_BITS-1:0] status_r, status_nxt;   // Sticky events
	logic [`CSEI_EV_BITS-1:0] mask_r, mask_nxt;       // Event enables
	logic [31:0]             vector_r, vector_nxt;    // Reset vector
	logic                    intErr_r, intErr_nxt;    // Held error
	logic                    cyc_r, cyc_nxt;          // Cycle pending
	logic                    initPrev_r, initPrev_nxt;
	logic                    fpExc_r, fpExc_nxt;      // Exception pulse
	csei_state_t             state_r, state_nxt;
	csei_snoop_t             snoop_r, snoop_nxt;
	logic                    cacheInv_r, cacheInv_nxt;
	// AXI state
	logic        awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
	logic [11:0] awAddr_r, awAddr_nxt;
	logic [31:0] wData_r, wData_nxt;
	logic [3:0]  wStrb_r, wStrb_nxt;
	logic        bValid_r, bValid_nxt, rValid_r, rValid_nxt;
	logic [1:0]  bResp_r, bResp_nxt, rResp_r, rResp_nxt;
	logic [31:0] rData_r, rData_nxt;

	// Helpers
	logic nativeErr, licEn, fpPending, fpOp, initEdge, doWrite, doRead;
	logic [`CSEI_EV_BITS-1:0] events;
	logic [31:0] wMask;
	assign nativeErr = ctrl_r[`CSEI_CTRL_NATIVE_BIT];
	assign licEn     = ctrl_r[`CSEI_CTRL_LIC_BIT];
	assign fpPending = ctrl_r[`CSEI_CTRL_FPERR_BIT];
	assign fpOp      = ctrl_r[`CSEI_CTRL_FPOP_BIT];
	assign initEdge  = asyncSync_r.initReq & ~initPrev_r;
	assign doWrite   = awHeld_r & wHeld_r & ~bValid_r;
	assign doRead    = s_axi_arvalid & ~rValid_r;
	assign s_axi_awready = ~awHeld_r & ~bValid_r;
	assign s_axi_wready  = ~wHeld_r & ~bValid_r;
	assign s_axi_arready = ~rValid_r;

	// Write strobe mask over all four lanes
	for (genvar g = 0; g < 4; g++)
	begin : g_lane
		assign wMask[g*8 +: 8] = {8{wStrb_r[g]}};
	end

	// ======================================================
	// Core behaviour next state
	// ======================================================
	// Error, numeric error, init sequencer and snoop
	always_comb
	begin
		intErr_nxt   = intErr_r;
		cyc_nxt      = 1'b0;
		fpExc_nxt    = 1'b0;
		state_nxt    = state_r;
		initPrev_nxt = asyncSync_r.initReq;
		cacheInv_nxt = 1'b0;
		snoop_nxt    = '0;
		// Error is held; only reset clears it
		if (internalErrorEvent || ctrl_r[`CSEI_CTRL_ERR_BIT])
		begin
			intErr_nxt = 1'b1;
			cyc_nxt    = ~intErr_r; // One bus_cycle_a cycle, for the first error until reset
		end
		// Ignore input masks only while native bit clear
		if (fpOp && fpPending)
			fpExc_nxt = nativeErr | ~asyncSync_r.ignoreNumericErrorIn;
		// Soft init sequencer
		unique case (state_r)
			CSEI_RUN:
				if (initEdge)
					state_nxt = CSEI_INIT;
			CSEI_INIT:
				if (!asyncSync_r.initReq)
					state_nxt = CSEI_FETCH;
			CSEI_FETCH:
				state_nxt = CSEI_RUN;
			default:
				state_nxt = CSEI_RUN;
		endcase
		// Snoops answered in every state, init included
		if (snoopReq)
		begin
			if (snoopNeedsStall || ctrl_r[`CSEI_CTRL_STALL_BIT])
				snoop_nxt = '{snoopHit: 1'b1, snoopHitModified: 1'b1};
			else
				// Dirty hit shows modified alone, never a stall
				snoop_nxt = '{snoopHit: snoopHitLine & ~snoopDirtyLine,
				              snoopHitModified: snoopDirtyLine};
		end
	end

	// Registered core state
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			intErr_r   <= 1'b0;
			cyc_r      <= 1'b0;
			fpExc_r    <= 1'b0;
			state_r    <= CSEI_RUN;
			initPrev_r <= 1'b0;
			cacheInv_r <= 1'b1; // Invalidate without writeback
			snoop_r    <= '0;
		end
		else
		begin
			intErr_r   <= intErr_nxt;
			cyc_r      <= cyc_nxt;
			fpExc_r    <= fpExc_nxt;
			state_r    <= state_nxt;
			initPrev_r <= initPrev_nxt;
			cacheInv_r <= cacheInv_nxt;
			snoop_r    <= snoop_nxt;
		end
	end

	// Events feeding the sticky status
	assign events[`CSEI_EV_INTERR] = intErr_nxt & ~intErr_r;
	assign events[`CSEI_EV_FPEXC] = fpExc_nxt;
	assign events[`CSEI_EV_INIT]  = initEdge;
	assign events[`CSEI_EV_IRQ]   = ~licEn & asyncSync_r.localIrqPinZero;
	assign events[`CSEI_EV_NMI]   = ~licEn & asyncSync_r.localIrqPinOne;

	// ======================================================
	// Register file and AXI4-Lite next state
	// ======================================================
	always_comb
	begin
		ctrl_nxt   = ctrl_r;
		mask_nxt   = mask_r;
		vector_nxt = vector_r;
		status_nxt = status_r;
		awHeld_nxt = awHeld_r | (s_axi_awvalid & s_axi_awready);
		wHeld_nxt  = wHeld_r | (s_axi_wvalid & s_axi_wready);
		awAddr_nxt = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awAddr_r;
		wData_nxt  = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wData_r;
		wStrb_nxt  = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wStrb_r;
		bValid_nxt = bValid_r & ~s_axi_bready;
		bResp_nxt  = bResp_r;
		rValid_nxt = rValid_r & ~s_axi_rready;
		rResp_nxt  = rResp_r;
		rData_nxt  = rData_r;
		// Float op strobe self-clears after one cycle
		ctrl_nxt[`CSEI_CTRL_FPOP_BIT] = 1'b0;
		if (doWrite)
		begin
			awHeld_nxt = 1'b0;
			wHeld_nxt  = 1'b0;
			bValid_nxt = 1'b1;
			bResp_nxt  = `CSEI_RESP_OKAY;
			unique case (awAddr_r)
				`CSEI_CTRL_OFF:   ctrl_nxt = (ctrl_r & ~wMask) | (wData_r & wMask);
				`CSEI_MASK_OFF:   mask_nxt = (mask_r & ~wMask[4:0])
				                           | (wData_r[4:0] & wMask[4:0]);
				`CSEI_VECTOR_OFF: vector_nxt = (vector_r & ~wMask)
				                             | (wData_r & wMask);
				`CSEI_STATUS_OFF, `CSEI_STATE_OFF: ;
				default: bResp_nxt = `CSEI_RESP_SLVERR;
			endcase
		end
		if (doRead)
		begin
			rValid_nxt = 1'b1;
			rResp_nxt  = `CSEI_RESP_OKAY;
			rData_nxt  = 32'h0000_0000;
			unique case (s_axi_araddr)
				`CSEI_CTRL_OFF:   rData_nxt = ctrl_r;
				`CSEI_MASK_OFF:   rData_nxt[4:0] = mask_r;
				`CSEI_VECTOR_OFF: rData_nxt = vector_r;
				`CSEI_STATE_OFF:  rData_nxt = {25'h0, state_r,
				                               asyncSync_r.ignoreNumericErrorIn,
				                               licEn, nativeErr, intErr_r};
				`CSEI_STATUS_OFF:
				begin
					rData_nxt[4:0] = status_r;
					status_nxt     = '0; // Read clears
				end
				default: rResp_nxt = `CSEI_RESP_SLVERR;
			endcase
		end
		// Set wins over clear-on-read
		status_nxt = status_nxt | events;
		// Soft init leaves vector and cache control alone
		if (state_r == CSEI_INIT)
			ctrl_nxt[`CSEI_CTRL_FPOP_BIT] = 1'b0;
	end

	// Registered register file and bus state
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_r   <= `CSEI_CTRL_RESET; // Controller on by default
			mask_r   <= `CSEI_MASK_RESET;
			vector_r <= `CSEI_VECTOR_RESET;
			status_r <= '0;
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			awAddr_r <= 12'h000;
			wData_r  <= 32'h0000_0000;
			wStrb_r  <= 4'h0;
			bValid_r <= 1'b0;
			bResp_r  <= 2'h0;
			rValid_r <= 1'b0;
			rResp_r  <= 2'h0;
			rData_r  <= 32'h0000_0000;
		end
		else
		begin
			ctrl_r   <= ctrl_nxt;
			mask_r   <= mask_nxt;
			vector_r <= vector_nxt;
			status_r <= status_nxt;
			awHeld_r <= awHeld_nxt;
			wHeld_r  <= wHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r  <= wData_nxt;
			wStrb_r  <= wStrb_nxt;
			bValid_r <= bValid_nxt;
			bResp_r  <= bResp_nxt;
			rValid_r <= rValid_nxt;
			rResp_r  <= rResp_nxt;
			rData_r  <= rData_nxt;
		end
	end

	// ======================================================
	// Outputs
	// ======================================================
	assign s_axi_bvalid       = bValid_r;
	assign s_axi_bresp        = bResp_r;
	assign s_axi_rvalid       = rValid_r;
	assign s_axi_rresp        = rResp_r;
	assign s_axi_rdata        = rData_r;
	assign snoopOut           = snoop_r;
	assign internal_error_out = intErr_r;
	assign busCycle           = cyc_r ? CSEI_CYC_BUS_CYCLE_A : CSEI_CYC_NONE;
	// Fallback routing when controller disabled
	assign maskable_irq   = ~licEn & asyncSync_r.localIrqPinZero;
	assign nmiOut         = ~licEn & asyncSync_r.localIrqPinOne;
	assign local_irq_pins = licEn ? {asyncSync_r.localIrqPinOne,
	                                 asyncSync_r.localIrqPinZero} : 2'h0;
	assign intRegReset     = (state_r == CSEI_INIT);
	assign cacheInvalidate = cacheInv_r;
	assign fetchStart      = (state_r == CSEI_FETCH);
	assign fetchVector     = vector_r;
	assign irq             = |(status_r & mask_r);

	// ======================================================
	// Assertions
	// ======================================================
	property p_errHeld;
		@(posedge core_clk) disable iff (!rstn)
		intErr_r |=> intErr_r;
	endproperty
	a_errHeld: assert property (p_errHeld)
		else $error("internal error output dropped before reset");

	property p_bus_cycle_a;
		@(posedge core_clk) disable iff (!rstn)
		$rose(intErr_r) |-> busCycle == CSEI_CYC_BUS_CYCLE_A ##1
		                  busCycle == CSEI_CYC_NONE;
	endproperty
	a_bus_cycle_a: assert property (p_bus_cycle_a)
		else $error("no single bus_cycle_a cycle with error");

	property p_ignore;
		@(posedge core_clk) disable iff (!rstn)
		(fpOp && fpPending && !nativeErr && asyncSync_r.ignoreNumericErrorIn)
		|=> !fpExc_r;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("exception raised while numeric error ignored");

	property p_except;
		@(posedge core_clk) disable iff (!rstn)
		(fpOp && fpPending &&
		 (nativeErr || !asyncSync_r.ignoreNumericErrorIn))
		|=> fpExc_r;
	endproperty
	a_except: assert property (p_except)
		else $error("missing numeric exception");

	property p_stall;
		@(posedge core_clk) disable iff (!rstn)
		(snoopReq && snoopNeedsStall) |=> snoopOut == 2'b11;
	endproperty
	a_stall: assert property (p_stall)
		else $error("snoop stall not signalled on both lines");

	property p_snoopInit;
		@(posedge core_clk) disable iff (!rstn)
		(snoopReq && state_r == CSEI_INIT && !snoopNeedsStall &&
		 !ctrl_r[`CSEI_CTRL_STALL_BIT])
		|=> snoopOut == {$past(snoopHitLine) & ~$past(snoopDirtyLine),
		                 $past(snoopDirtyLine)};
	endproperty
	a_snoopInit: assert property (p_snoopInit)
		else $error("snoop not serviced during soft init");

	property p_fetch;
		@(posedge core_clk) disable iff (!rstn)
		(state_r == CSEI_INIT && !asyncSync_r.initReq)
		|=> fetchStart && fetchVector == vector_r ##1 !fetchStart;
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch not restarted after soft init");

	property p_fallback;
		@(posedge core_clk) disable iff (!rstn)
		!licEn |-> maskable_irq == asyncSync_r.localIrqPinZero &&
		           nmiOut == asyncSync_r.localIrqPinOne &&
		           local_irq_pins == 2'h0;
	endproperty
	a_fallback: assert property (p_fallback)
		else $error("pins not routed as maskable and nonmaskable");

	property p_sync;
		@(posedge core_clk) disable iff (!rstn)
		$rose(asyncIn.initReq) ##1 asyncIn.initReq
		|-> !asyncSync_r.initReq ##1 asyncSync_r.initReq;
	endproperty
	a_sync: assert property (p_sync)
		else $error("synchroniser latency not two cycles");
endmodule

// [test/csei_core_model.sv]
// Core logic partner model: drives the sideband pins, watches bus cycles
`timescale 1ns/10ps
module csei_core_model
	import csei_pkg::*;
(
	input  wire logic        core_clk,  // Bus clock
	input  wire logic        resetn,    // Active low reset
	input  wire csei_async_t pinReq,    // Levels asked for by the bench
	input  wire csei_cycle_t busCycle,  // Cycles issued by the unit
	output csei_async_t      asyncIn,   // Pins into the unit
	output logic             errorNmi   // Error indication from bus_cycle_a
);
	// ==========
	// Pin drivers
	// Off-edge delay keeps pins unrelated to the clock phase
	assign #3.3 asyncIn = pinReq;
	// Bus_cycle_a cycle turned into a nonmaskable error, held until reset
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			errorNmi <= 1'b0;
		else if (busCycle == CSEI_CYC_BUS_CYCLE_A)
			errorNmi <= 1'b1;
	end
endmodule

// [test/cpu_sideband_error_init_logic_tb_top.sv]
// Self-checking bench of the sideband error and init unit
`timescale 1ns/10ps
`include "csei_regs.svh"
module cpu_sideband_error_init_logic_tb_top
	import csei_pkg::*;
;
	// ==========
	// Signals
	logic        core_clk, resetn, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, fetchVector, rnd, fv;
	logic [1:0]  bresp, rresp, lirq, pv;
	csei_async_t pinReq, asyncIn;
	csei_snoop_t snoopOut;
	csei_cycle_t busCycle;
	logic        errEv, snoopReq, needStall, hitLine, dirtyLine, maskIrq;
	logic        nmiOut, errOut, intRegReset, cacheInv, fetchStart, irq;
	logic        errorNmi;
	int          miscompares, totalChecks, cycles, m, n, ctrlM, vecM;
	localparam logic [1:0] respOk  = `CSEI_RESP_OKAY;
	localparam logic [1:0] respErr = `CSEI_RESP_SLVERR;

	cpu_sideband_error_init_logic dut_u (.core_clk(core_clk),
		.resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .asyncIn(asyncIn),
		.internalErrorEvent(errEv), .snoopReq(snoopReq),
		.snoopNeedsStall(needStall), .snoopHitLine(hitLine),
		.snoopDirtyLine(dirtyLine), .snoopOut(snoopOut),
		.internal_error_out(errOut), .busCycle(busCycle),
		.maskable_irq(maskIrq), .nmiOut(nmiOut), .local_irq_pins(lirq),
		.intRegReset(intRegReset), .cacheInvalidate(cacheInv),
		.fetchStart(fetchStart), .fetchVector(fetchVector), .irq(irq));
	csei_core_model partner_u (.core_clk(core_clk), .resetn(resetn),
		.pinReq(pinReq), .busCycle(busCycle), .asyncIn(asyncIn),
		.errorNmi(errorNmi));

	// ==========
	// Clock and hang guard
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Whole run needs well under this many cycles
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			print_verdict();
		end
	end

	// ==========
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
		chk_reg({30'h0, got}, {30'h0, exp});
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		forever
		begin
			@(posedge core_clk);
			if (bvalid)
				break;
			if (awready && !aw)
			begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w)
			begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b0;
		chk_pin(bresp, er);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge core_clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		forever
		begin
			@(posedge core_clk);
			if (rvalid)
				break;
			if (arready)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk_reg(rdata, ed);
		chk_pin(rresp, er);
	endtask
	// Snoop request pulse, result looked at one cycle later
	task automatic snoop(input logic st, h, d, input logic [1:0] e);
		@(posedge core_clk);
		{snoopReq, needStall, hitLine, dirtyLine} <= {1'b1, st, h, d};
		@(posedge core_clk);
		snoopReq <= 1'b0;
		@(posedge core_clk);
		chk_pin(snoopOut, e);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========
	// Main sequence
	initial
	begin
		rnd = 32'hF4AA;
		{resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{errEv, snoopReq, needStall, hitLine, dirtyLine} = '0;
		{awaddr, araddr, wdata} = '0;
		pinReq = '0;
		tick(16);
		resetn <= 1'b1;
		tick(3);
		// Reset values, read-only and unmapped places
		ctrlM = `CSEI_CTRL_RESET;
		rd(`CSEI_CTRL_OFF, ctrlM, respOk);
		rd(`CSEI_VECTOR_OFF, `CSEI_VECTOR_RESET, respOk);
		rd(`CSEI_MASK_OFF, 32'h0, respOk);
		wr(`CSEI_STATE_OFF, 32'hFF, respOk);
		rd(`CSEI_STATE_OFF, 32'h14, respOk);
		wr(12'h100, 32'h0, respErr);
		rd(12'h100, 32'h0, respErr);
		// Local pins, controller on then off
		for (m = 0; m < 8; m++)
		begin
			if (m == 4)
			begin
				ctrlM = 0;
				wr(`CSEI_CTRL_OFF, 32'h0, respOk);
			end
			pv = m[1:0];
			pinReq <= csei_async_t'({2'b00, pv});
			tick(5);
			chk_pin(lirq, ctrlM[1] ? pv : 2'b00);
			chk_pin({nmiOut, maskIrq}, ctrlM[1] ? 2'b00 : pv);
		end
		pinReq <= '0;
		tick(5);
		rd(`CSEI_STATUS_OFF, 32'h18, respOk);
		rd(`CSEI_STATUS_OFF, 32'h0, respOk);
		// Numeric error with every ignore and native bit pair
		for (m = 0; m < 4; m++)
		begin
			pinReq <= csei_async_t'({1'b0, m[1], 2'b00});
			tick(5); // Ignore input settles before the write
			wr(`CSEI_CTRL_OFF, 32'h18 | m[0], respOk);
			tick(2);
			rd(`CSEI_STATUS_OFF, (m[1] && !m[0]) ? 0 : 2, respOk);
		end
		rd(`CSEI_CTRL_OFF, 32'h9, respOk);
		// Snoop results, forced stall from the ninth case on
		for (m = 0; m < 16; m++)
		begin
			if (m == 8)
				wr(`CSEI_CTRL_OFF, 32'h20, respOk);
			snoop(m[2], m[1], m[1] & m[0], (m[2] | m[3]) ? 2'b11 :
				(m[1] & m[0]) ? 2'b01 : m[1] ? 2'b10 : 2'b00);
		end
		wr(`CSEI_CTRL_OFF, 32'h0, respOk);
		// Soft init with a snoop in the middle
		rnd = lfsr(rnd);
		vecM = rnd;
		wr(`CSEI_VECTOR_OFF, vecM, respOk);
		pinReq <= csei_async_t'(4'h8);
		tick(8);
		chk_pin({intRegReset, cacheInv}, 2'b10);
		snoop(1'b0, 1'b1, 1'b0, 2'b10);
		pinReq <= '0;
		n = 0;
		repeat (10)
		begin
			@(posedge core_clk);
			if (fetchStart === 1'b1)
			begin
				n++;
				fv = fetchVector;
			end
		end
		chk_pin(n[1:0], 2'b01);
		chk_reg(fv, vecM);
		rd(`CSEI_STATUS_OFF, 32'h4, respOk);
		// Internal error, bus_cycle_a cycle and masked interrupt
		wr(`CSEI_MASK_OFF, 32'h1, respOk);
		@(posedge core_clk);
		errEv <= 1'b1;
		@(posedge core_clk);
		errEv <= 1'b0;
		n = 0;
		repeat (4)
		begin
			@(posedge core_clk);
			if (busCycle === CSEI_CYC_BUS_CYCLE_A)
				n++;
		end
		chk_pin(n[1:0], 2'b01);
		tick(20);
		chk_pin({errOut, irq}, 2'b11);
		chk_pin({1'b0, errorNmi}, 2'b01);
		rd(`CSEI_STATUS_OFF, 32'h1, respOk);
		tick(2);
		chk_pin({errOut, irq}, 2'b10);
		// Second reset clears the held error
		resetn <= 1'b0;
		tick(2);
		chk_pin({errOut, cacheInv}, 2'b01);
		resetn <= 1'b1;
		tick(3);
		rd(`CSEI_CTRL_OFF, `CSEI_CTRL_RESET, respOk);
		// Error forced through the control bit raises the output and the status
		wr(`CSEI_CTRL_OFF, 32'h4, respOk);
		tick(2);
		chk_pin({1'b0, errOut}, 2'b01);
		rd(`CSEI_STATUS_OFF, 32'h1, respOk);
		print_verdict();
	end
endmodule
